// ==== core/pmrs_regs.svh ====
`ifndef PMRS_REGS_SVH
`define PMRS_REGS_SVH

// ****************************************************************
// power control register
// ****************************************************************
`define PMRS_POWER_CONTROL_ADDR 8'h87
`define PMRS_POWER_CONTROL_RESET 8'h00
`define PMRS_BIT_UART1_DOUBLE 7
`define PMRS_BIT_UART2_DOUBLE 6
`define PMRS_BIT_LVR_DISABLE 5
`define PMRS_BIT_ADC_IRQ_EN 4
`define PMRS_BIT_UART2_RXCLK 3
`define PMRS_BIT_UART2_TXCLK 2
`define PMRS_BIT_POWERDOWN 1
`define PMRS_BIT_CPU_HALT 0

// ****************************************************************
// timing
// ****************************************************************
`define PMRS_CLK_PERIOD_NS 10
`define PMRS_LVR_FILTER_NS 1000
`define PMRS_LVR_HOLD_MS 10
`define PMRS_LVR_FILTER_CYC \
    ((`PMRS_LVR_FILTER_NS + `PMRS_CLK_PERIOD_NS - 1) / `PMRS_CLK_PERIOD_NS)
`define PMRS_LVR_HOLD_CYC \
    ((`PMRS_LVR_HOLD_MS * 1000000 + `PMRS_CLK_PERIOD_NS - 1) / `PMRS_CLK_PERIOD_NS)
`define PMRS_RESTART_CYC 3

`endif

// ==== core/pmrs_pkg.sv ====
package pmrs_pkg;

    // ****************************************************************
    // operating modes, one-hot
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_RUN = 3'b001,
        MODE_IDLE = 3'b010,
        MODE_PDOWN = 3'b100
    } pmrs_mode_t;

    typedef struct packed {
        logic [1:0] rel;
    } pmrs_merge_state_t;

    typedef struct packed {
        logic [7:0] power_control;
        pmrs_mode_t mode;
        logic [1:0] ext_sync;
        logic [1:0] low_sync;
        logic [6:0] lvr_filt;
        logic lvr_low;
        logic [19:0] lvr_hold;
        logic lvr_assert;
        logic wdt_src;
        logic usb_src;
        logic usb_flag;
        logic [1:0] restart_cnt;
        logic cpu_run;
        logic cpu_halt;
        logic clk_stop;
        logic periph_en;
        logic sys_reset;
        logic clm_reset_n;
        logic [7:0] rdata;
    } pmrs_state_t;

endpackage : pmrs_pkg

// ==== core/pmrs_rst_if.sv ====
`timescale 1ns/100ps

interface pmrs_rst_if;
    logic src_ext;
    logic src_lvr;
    logic src_wdt;
    logic src_usb;
    logic int_rst_n;

    modport src (
        output src_ext,
        output src_lvr,
        output src_wdt,
        output src_usb,
        input int_rst_n
    );

    modport merge (
        input src_ext,
        input src_lvr,
        input src_wdt,
        input src_usb,
        output int_rst_n
    );
endinterface : pmrs_rst_if

// ==== core/pmrs_reset_merge.sv ====
`timescale 1ns/100ps

module pmrs_reset_merge (
    // clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // reset sources and merged reset
    pmrs_rst_if.merge rif
);

    pmrs_pkg::pmrs_merge_state_t st_reg;
    pmrs_pkg::pmrs_merge_state_t st_next;
    logic any_src_n;

    // ****************************************************************
    // merge
    // ****************************************************************
    // four sources merged
    assign any_src_n = rst_n & ~(rif.src_ext | rif.src_lvr | rif.src_wdt | rif.src_usb);

    always_comb begin
        st_next = st_reg;
        st_next.rel = {st_reg.rel[0], 1'b1};
    end

    always_ff @(posedge clk_sys or negedge any_src_n) begin
        if (!any_src_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rif.int_rst_n = st_reg.rel[1];

endmodule : pmrs_reset_merge

// ==== core/pmrs_top.sv ====
// Function
// - idle halts only the cpu
// - idle ends on interrupt or reset only
// - power-down stops clock, disables pwm/i2c/usb
// - registers hold value through power-down
// - only reset leaves power-down
// - idle starts right after the setting write
// - idle keeps all cpu state
// - enabled interrupt clears idle bit, resumes
// - cpu restarts three cycles after reset
// - bit 1 requests power-down
// - bit 0 requests idle; reset 00
// - other bits: baud, adc irq, uart2 clocks
// - four reset sources accepted
// - any source resets cpu and logic module
// - supply low asserts reset, 10ms hold
// - low-voltage reset on by default, bit 5
// - low-voltage reset works in all modes
// - supply detector filtered about 1us
// - watchdog overflow asserts reset
// - usb reset sets flag, optional forward
`timescale 1ns/100ps
`include "pmrs_regs.svh"

module pmrs_top #(
    parameter int unsigned LVR_HOLD_CYC = `PMRS_LVR_HOLD_CYC
) (
    // clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // cpu side
    input wire logic irq_wake,
    output logic cpu_halt,
    output logic cpu_run,
    // clock and peripheral gating
    output logic clk_stop,
    output logic periph_pd_enable,
    // reset sources
    input wire logic ext_reset_pin_n,
    input wire logic supply_low_raw,
    input wire logic wdt_overflow,
    input wire logic usb_reset_detect,
    input wire logic usb_reset_forward_enable,
    input wire logic usb_flag_clear,
    output logic usb_reset_seen_flag,
    // merged resets
    output logic sys_reset,
    output logic clm_reset_n,
    // settings for other blocks
    output logic uart1_baud_double,
    output logic uart2_baud_double,
    output logic adc_irq_enable,
    output logic uart2_rx_clock_flag,
    output logic uart2_tx_clock_flag
);

    localparam int FILT_CYC = `PMRS_LVR_FILTER_CYC;
    localparam int RESTART_CYC = `PMRS_RESTART_CYC;

    pmrs_pkg::pmrs_state_t st_reg;
    pmrs_pkg::pmrs_state_t st_next;
    logic power_control_write;
    logic power_control_read;
    logic [7:0] wval;

    pmrs_rst_if rif ();

    pmrs_reset_merge u_merge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rif(rif)
    );

    // ****************************************************************
    // register access
    // ****************************************************************
    // register frozen in power-down
    // writes ignored while frozen in power-down or before restart
    assign power_control_write = sfr_wr && (sfr_addr == `PMRS_POWER_CONTROL_ADDR) && st_reg.cpu_run
        && (st_reg.mode != pmrs_pkg::MODE_PDOWN);
    assign power_control_read = sfr_rd && (sfr_addr == `PMRS_POWER_CONTROL_ADDR);

    always_comb begin
        st_next = st_reg;
        wval = sfr_wdata;

        // ****************************************************************
        // pin synchronisers
        // ****************************************************************
        // pin sampled each cycle
        st_next.ext_sync = {st_reg.ext_sync[0], ext_reset_pin_n};
        st_next.low_sync = {st_reg.low_sync[0], supply_low_raw};

        // ****************************************************************
        // low-voltage reset
        // ****************************************************************
        // dips shorter than filter ignored
        if (!st_reg.low_sync[1]) begin
            st_next.lvr_filt = '0;
            st_next.lvr_low = 1'b0;
        end else if (!st_reg.lvr_low) begin
            if (st_reg.lvr_filt == 7'(FILT_CYC - 1)) begin
                st_next.lvr_low = 1'b1;
            end else begin
                st_next.lvr_filt = st_reg.lvr_filt + 7'h01;
            end
        end
        // assert on low, hold after recovery
        if (st_reg.lvr_low) begin
            st_next.lvr_assert = 1'b1;
            st_next.lvr_hold = '0;
        end else if (st_reg.lvr_assert) begin
            if (st_reg.lvr_hold == 20'(LVR_HOLD_CYC - 1)) begin
                st_next.lvr_assert = 1'b0;
            end else begin
                st_next.lvr_hold = st_reg.lvr_hold + 20'h00001;
            end
        end
        // disable bit, clear after any reset
        if (st_reg.power_control[`PMRS_BIT_LVR_DISABLE]) begin
            st_next.lvr_assert = 1'b0;
        end

        // ****************************************************************
        // other sources
        // ****************************************************************
        // watchdog overflow
        st_next.wdt_src = wdt_overflow;
        st_next.usb_src = usb_reset_detect && usb_reset_forward_enable;
        if (usb_reset_detect) begin
            st_next.usb_flag = 1'b1;
        end else if (usb_flag_clear) begin
            st_next.usb_flag = 1'b0;
        end

        // ****************************************************************
        // mode machine
        // ****************************************************************
        case (st_reg.mode)
            pmrs_pkg::MODE_RUN: begin
                if (power_control_write) begin
                    if (wval[`PMRS_BIT_POWERDOWN]) begin
                        wval[`PMRS_BIT_CPU_HALT] = 1'b0;
                        st_next.mode = pmrs_pkg::MODE_PDOWN;
                    end else if (wval[`PMRS_BIT_CPU_HALT]) begin
                        st_next.mode = pmrs_pkg::MODE_IDLE;
                    end
                    st_next.power_control = wval;
                end
            end
            pmrs_pkg::MODE_IDLE: begin
                if (irq_wake) begin
                    st_next.power_control[`PMRS_BIT_CPU_HALT] = 1'b0;
                    st_next.mode = pmrs_pkg::MODE_RUN;
                end
            end
            pmrs_pkg::MODE_PDOWN: begin
                st_next.mode = pmrs_pkg::MODE_PDOWN;
            end
            default: begin
                st_next.mode = pmrs_pkg::MODE_RUN;
            end
        endcase

        // ****************************************************************
        // restart after internal reset
        // ****************************************************************
        // run three cycles after release
        if (!st_reg.cpu_run) begin
            if (st_reg.restart_cnt == 2'(RESTART_CYC - 1)) begin
                st_next.cpu_run = 1'b1;
            end else begin
                st_next.restart_cnt = st_reg.restart_cnt + 2'h1;
            end
        end

        // internal reset returns core state to defaults
        if (!rif.int_rst_n) begin
            st_next.power_control = `PMRS_POWER_CONTROL_RESET;
            st_next.mode = pmrs_pkg::MODE_RUN;
            st_next.restart_cnt = '0;
            st_next.cpu_run = 1'b0;
        end

        // ****************************************************************
        // registered outputs
        // ****************************************************************
        // halt freezes cpu only
        st_next.cpu_halt = (st_next.mode == pmrs_pkg::MODE_IDLE);
        st_next.clk_stop = (st_next.mode == pmrs_pkg::MODE_PDOWN);
        st_next.periph_en = (st_next.mode != pmrs_pkg::MODE_PDOWN);
        // cpu reset and active-low module reset
        st_next.sys_reset = ~rif.int_rst_n;
        st_next.clm_reset_n = rif.int_rst_n;
        st_next.rdata = power_control_read ? st_reg.power_control : 8'h00;
    end

    // supervisor keeps running on the free clock in every mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.mode <= pmrs_pkg::MODE_RUN;
            st_reg.ext_sync <= 2'h3;
            st_reg.periph_en <= 1'b1;
            st_reg.sys_reset <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rif.src_ext = ~st_reg.ext_sync[1];
    assign rif.src_lvr = st_reg.lvr_assert;
    assign rif.src_wdt = st_reg.wdt_src;
    assign rif.src_usb = st_reg.usb_src;

    assign sfr_rdata = st_reg.rdata;
    assign cpu_halt = st_reg.cpu_halt;
    assign cpu_run = st_reg.cpu_run;
    assign clk_stop = st_reg.clk_stop;
    assign periph_pd_enable = st_reg.periph_en;
    assign usb_reset_seen_flag = st_reg.usb_flag;
    assign sys_reset = st_reg.sys_reset;
    assign clm_reset_n = st_reg.clm_reset_n;
    assign uart1_baud_double = st_reg.power_control[`PMRS_BIT_UART1_DOUBLE];
    assign uart2_baud_double = st_reg.power_control[`PMRS_BIT_UART2_DOUBLE];
    assign adc_irq_enable = st_reg.power_control[`PMRS_BIT_ADC_IRQ_EN];
    assign uart2_rx_clock_flag = st_reg.power_control[`PMRS_BIT_UART2_RXCLK];
    assign uart2_tx_clock_flag = st_reg.power_control[`PMRS_BIT_UART2_TXCLK];

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_idle_entry_next: assert property (
        power_control_write && sfr_wdata[0] && !sfr_wdata[1] && rif.int_rst_n |=> cpu_halt)
        else $error("idle not entered after write");

    chk_pd_over_idle: assert property (
        power_control_write && sfr_wdata[0] && sfr_wdata[1] && rif.int_rst_n
        |=> clk_stop && !cpu_halt && !st_reg.power_control[0])
        else $error("both bits did not select power-down");

    chk_pd_no_wake: assert property (
        clk_stop && irq_wake && rif.int_rst_n |=> clk_stop)
        else $error("interrupt left power-down");

    chk_pd_power_control_hold: assert property (
        clk_stop && rif.int_rst_n |=> $stable(st_reg.power_control))
        else $error("register changed in power-down");

    chk_idle_wake_clear: assert property (
        st_reg.mode == pmrs_pkg::MODE_IDLE && irq_wake && rif.int_rst_n
        |=> !cpu_halt && !st_reg.power_control[0])
        else $error("interrupt did not end idle");

    chk_idle_stays: assert property (
        st_reg.mode == pmrs_pkg::MODE_IDLE && !irq_wake && rif.int_rst_n |=> cpu_halt)
        else $error("idle left without cause");

    chk_restart_three: assert property (
        $rose(rif.int_rst_n) |-> !cpu_run ##1 !cpu_run ##1 !cpu_run ##1 cpu_run)
        else $error("restart not three cycles after release");

    chk_usb_forward_rst: assert property (
        usb_reset_detect && usb_reset_forward_enable |-> ##[1:3] sys_reset)
        else $error("usb reset not forwarded");

    chk_usb_flag_set: assert property (
        usb_reset_detect |=> usb_reset_seen_flag)
        else $error("usb reset flag not set");

    chk_lvr_filter_len: assert property (
        $rose(st_reg.lvr_low) |-> $past(st_reg.lvr_filt) == 7'(FILT_CYC - 1))
        else $error("supply filter too short");

    chk_lvr_disabled: assert property (
        st_reg.power_control[`PMRS_BIT_LVR_DISABLE] |=> !st_reg.lvr_assert)
        else $error("low-voltage reset while disabled");

    cov_idle_wake: cover property (cpu_halt ##1 !cpu_halt && !sys_reset);
    cov_pd_enter: cover property ($rose(clk_stop));
    cov_lvr_reset: cover property ($rose(st_reg.lvr_assert));
    cov_usb_fwd: cover property (usb_reset_detect && usb_reset_forward_enable);

endmodule : pmrs_top

// ==== tb/pmrs_top_tb.sv ====
`timescale 1ns/100ps

module pmrs_top_tb;
    localparam int HOLD = 20;

    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic irq_wake = 1'b0;
    logic cpu_halt, cpu_run, clk_stop, periph_pd_enable;
    logic ext_reset_pin_n = 1'b0;
    logic supply_low_raw = 1'b0;
    logic wdt_overflow = 1'b0;
    logic usb_reset_detect = 1'b0;
    logic usb_reset_forward_enable = 1'b0;
    logic usb_flag_clear = 1'b0;
    logic usb_reset_seen_flag, sys_reset, clm_reset_n;
    logic u1d, u2d, adc_en, u2rx, u2tx;
    int rst_edges = 0;
    logic [7:0] rv;
    int bad_count = 0;
    int samples_checked = 0;

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (sys_reset === 1'b1) rst_edges <= rst_edges + 1;

    pmrs_top #(.LVR_HOLD_CYC(HOLD)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .irq_wake(irq_wake), .cpu_halt(cpu_halt), .cpu_run(cpu_run),
        .clk_stop(clk_stop), .periph_pd_enable(periph_pd_enable),
        .ext_reset_pin_n(ext_reset_pin_n), .supply_low_raw(supply_low_raw),
        .wdt_overflow(wdt_overflow), .usb_reset_detect(usb_reset_detect),
        .usb_reset_forward_enable(usb_reset_forward_enable),
        .usb_flag_clear(usb_flag_clear), .usb_reset_seen_flag(usb_reset_seen_flag),
        .sys_reset(sys_reset), .clm_reset_n(clm_reset_n),
        .uart1_baud_double(u1d), .uart2_baud_double(u2d), .adc_irq_enable(adc_en),
        .uart2_rx_clock_flag(u2rx), .uart2_tx_clock_flag(u2tx)
    );

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task chk_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task step;
        @(posedge clk_sys);
        #1;
    endtask : step

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask : rd

    task wait_rst(input int limit);
        int i;
        i = 0;
        while (sys_reset !== 1'b1 && i < limit) begin
            step();
            i++;
        end
        chk_bit("sys_reset", 1'b1, sys_reset);
        chk_bit("clm_reset_n", 1'b0, clm_reset_n);
    endtask : wait_rst

    // release of the merged reset, then the restart gap to cpu_run
    task release_chk;
        int i;
        int n;
        i = 0;
        n = 0;
        while (sys_reset !== 1'b0 && i < HOLD + 100) begin
            step();
            i++;
        end
        while (cpu_run !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        // sys_reset trails the merged reset by one edge: gap is 3 - 1
        chk_bit("restart_gap", 1'b1, n == 2);
        chk_bit("clm_reset_n", 1'b1, clm_reset_n);
        rd(8'h87, rv);
        chk_byte("power_control_reg", 8'h00, rv);
    endtask : release_chk

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task s_reset;
        release_chk();
        chk_bit("cpu_halt", 1'b0, cpu_halt);
        chk_bit("periph_pd_enable", 1'b1, periph_pd_enable);
        rd(8'h55, rv);
        chk_byte("unmapped_read", 8'h00, rv);
    endtask : s_reset

    task s_settings;
        wr(8'h87, 8'hdc);
        chk_byte("setting_bits", 8'h1f, {3'h0, u1d, u2d, adc_en, u2rx, u2tx});
        wr(8'h86, 8'hff);
        rd(8'h87, rv);
        chk_byte("power_control_reg", 8'hdc, rv);
        chk_bit("cpu_halt", 1'b0, cpu_halt);
        wr(8'h87, 8'h00);
        chk_byte("setting_bits", 8'h00, {3'h0, u1d, u2d, adc_en, u2rx, u2tx});
    endtask : s_settings

    task s_idle;
        wr(8'h87, 8'h11);
        chk_bit("cpu_halt", 1'b1, cpu_halt);
        chk_bit("clk_stop", 1'b0, clk_stop);
        chk_bit("periph_pd_enable", 1'b1, periph_pd_enable);
        repeat (6) step();
        chk_bit("cpu_halt", 1'b1, cpu_halt);
        chk_bit("adc_irq_enable", 1'b1, adc_en);
        @(posedge clk_sys);
        irq_wake <= 1'b1;
        @(posedge clk_sys);
        irq_wake <= 1'b0;
        #1;
        chk_bit("cpu_halt", 1'b0, cpu_halt);
        rd(8'h87, rv);
        chk_byte("power_control_reg", 8'h10, rv);
    endtask : s_idle

    task s_pdown;
        int n;
        wr(8'h87, 8'h03);
        chk_bit("clk_stop", 1'b1, clk_stop);
        chk_bit("periph_pd_enable", 1'b0, periph_pd_enable);
        @(posedge clk_sys);
        irq_wake <= 1'b1;
        @(posedge clk_sys);
        irq_wake <= 1'b0;
        repeat (3) step();
        chk_bit("clk_stop", 1'b1, clk_stop);
        wr(8'h87, 8'h00);
        chk_bit("clk_stop", 1'b1, clk_stop);
        rd(8'h87, rv);
        chk_byte("power_control_reg", 8'h02, rv);
        @(posedge clk_sys);
        supply_low_raw <= 1'b1;
        wait_rst(130);
        chk_bit("clk_stop", 1'b0, clk_stop);
        repeat (5) step();
        @(posedge clk_sys);
        supply_low_raw <= 1'b0;
        n = 0;
        while (sys_reset !== 1'b0 && n < HOLD + 60) begin
            step();
            n++;
        end
        chk_bit("lvr_hold", 1'b1, n >= HOLD && n <= HOLD + 8);
        release_chk();
    endtask : s_pdown

    task s_lvr;
        int base;
        base = rst_edges;
        @(posedge clk_sys);
        supply_low_raw <= 1'b1;
        repeat (50) @(posedge clk_sys);
        supply_low_raw <= 1'b0;
        repeat (10) step();
        chk_bit("short_dip_reset", 1'b0, rst_edges != base);
        wr(8'h87, 8'h20);
        @(posedge clk_sys);
        supply_low_raw <= 1'b1;
        repeat (150) @(posedge clk_sys);
        supply_low_raw <= 1'b0;
        repeat (5) step();
        chk_bit("lvr_disabled_reset", 1'b0, rst_edges != base);
        wr(8'h87, 8'h00);
    endtask : s_lvr

    task s_wdt;
        wr(8'h87, 8'h01);
        chk_bit("cpu_halt", 1'b1, cpu_halt);
        @(posedge clk_sys);
        wdt_overflow <= 1'b1;
        @(posedge clk_sys);
        wdt_overflow <= 1'b0;
        wait_rst(4);
        release_chk();
        chk_bit("cpu_halt", 1'b0, cpu_halt);
    endtask : s_wdt

    task s_usb;
        int base;
        base = rst_edges;
        @(posedge clk_sys);
        usb_reset_forward_enable <= 1'b0;
        usb_reset_detect <= 1'b1;
        @(posedge clk_sys);
        usb_reset_detect <= 1'b0;
        repeat (6) step();
        chk_bit("usb_reset_seen_flag", 1'b1, usb_reset_seen_flag);
        chk_bit("usb_unforwarded_reset", 1'b0, rst_edges != base);
        @(posedge clk_sys);
        usb_flag_clear <= 1'b1;
        @(posedge clk_sys);
        usb_flag_clear <= 1'b0;
        step();
        chk_bit("usb_reset_seen_flag", 1'b0, usb_reset_seen_flag);
        @(posedge clk_sys);
        usb_reset_forward_enable <= 1'b1;
        usb_reset_detect <= 1'b1;
        @(posedge clk_sys);
        usb_reset_detect <= 1'b0;
        wait_rst(4);
        release_chk();
        @(posedge clk_sys);
        usb_reset_forward_enable <= 1'b0;
    endtask : s_usb

    task s_ext;
        wr(8'h87, 8'hc0);
        @(posedge clk_sys);
        ext_reset_pin_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        ext_reset_pin_n <= 1'b1;
        wait_rst(6);
        release_chk();
        chk_bit("uart1_baud_double", 1'b0, u1d);
    endtask : s_ext

    // ****************************************************************
    // run control
    // ****************************************************************
    task results;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        // pin held through power-up
        // span shortened: a full 10ms would blow the cycle budget
        repeat (4) @(posedge clk_sys);
        ext_reset_pin_n <= 1'b1;
        s_reset();
        s_settings();
        s_idle();
        s_pdown();
        s_lvr();
        s_wdt();
        s_usb();
        s_ext();
        results();
    end

    // whole run needs well under 3000 cycles
    initial begin
        #200000;
        bad_count++;
        results();
    end
endmodule : pmrs_top_tb
